/* src/acg_pkg.sv */
// Constants, register map and types for the port-two clock generator
package acg_pkg;
   // Register indices; byte address is four times the index
   localparam logic [11:0] IDX_PATH_CTRL = 12'h320;
   localparam logic [11:0] IDX_BIT_CLOCK_CTRL = 12'h321;
   localparam logic [11:0] IDX_TX_FRAME_RATE = 12'h322;
   localparam logic [11:0] IDX_TX_FRAME_CTRL = 12'h323;
   localparam logic [11:0] IDX_RX_FRAME_RATE = 12'h324;
   localparam logic [11:0] IDX_RX_FRAME_CTRL = 12'h325;
   localparam int unsigned ADDR_SHIFT = 2;
   // Path control fields
   localparam int unsigned F_RX_EN_LO = 0;
   localparam int unsigned F_RX_EN_HI = 1;
   localparam int unsigned F_TX_EN_LO = 2;
   localparam int unsigned F_TX_EN_HI = 3;
   localparam int unsigned F_DSP_SRC = 4;
   localparam int unsigned F_PIN_TX_FN = 8;
   // Bit clock control fields
   localparam int unsigned F_BCLK_DIV_LO = 0;
   localparam int unsigned F_BCLK_DIV_HI = 3;
   localparam int unsigned F_BCLK_MSTR = 8;
   localparam int unsigned F_BCLK_FRC = 9;
   localparam int unsigned F_BCLK_INV = 10;
   // Frame control fields
   localparam int unsigned F_FR_MSTR = 0;
   localparam int unsigned F_FR_FRC = 1;
   localparam int unsigned F_FR_INV = 2;
   localparam int unsigned F_FR_MODE = 3;
   localparam int unsigned RATE_W = 11;
   // Reset values
   localparam logic [15:0] RST_PATH_CTRL = 16'h0000;
   localparam logic [15:0] RST_BIT_CLOCK_CTRL = 16'h0000;
   localparam logic [15:0] RST_FRAME_RATE = 16'h0080;
   localparam logic [15:0] RST_TX_FRAME_CTRL = 16'h0008;
   localparam logic [15:0] RST_RX_FRAME_CTRL = 16'h0000;
   localparam logic [RATE_W-1:0] RATE_MIN = 11'h008;
   // Writable masks
   localparam logic [15:0] MSK_PATH_CTRL = 16'h011f;
   localparam logic [15:0] MSK_BIT_CLOCK_CTRL = 16'h070f;
   localparam logic [15:0] MSK_FRAME_RATE = 16'h07ff;
   localparam logic [15:0] MSK_TX_FRAME_CTRL = 16'h000f;
   localparam logic [15:0] MSK_RX_FRAME_CTRL = 16'h0007;
   // Bit clock division ratios
   localparam logic [6:0] DIV_1 = 7'h01;
   localparam logic [6:0] DIV_2 = 7'h02;
   localparam logic [6:0] DIV_3 = 7'h03;
   localparam logic [6:0] DIV_4 = 7'h04;
   localparam logic [6:0] DIV_6 = 7'h06;
   localparam logic [6:0] DIV_8 = 7'h08;
   localparam logic [6:0] DIV_12 = 7'h0c;
   localparam logic [6:0] DIV_16 = 7'h10;
   localparam logic [6:0] DIV_24 = 7'h18;
   localparam logic [6:0] DIV_32 = 7'h20;
   localparam logic [6:0] DIV_48 = 7'h30;
   localparam logic [6:0] DIV_64 = 7'h40;
   localparam logic [6:0] DIV_96 = 7'h60;
   typedef enum logic [1:0] {ACG_IDLE, ACG_ACCESS} acg_bus_e;
   typedef struct packed {
      logic       out;
      logic       oe;
   } acg_pin_s;
endpackage : acg_pkg

/* src/acg_clock_gen.sv */
// Port-two bit clock and frame clock generator with APB registers
`timescale 1ns/1ps
module acg_clock_gen #(
   parameter int unsigned DATA_W = 24
) (
   input  wire logic                ref_clk,
   input  wire logic                nrst,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                audioSystemClock,
   input  wire logic                bitClockIn,
   output logic                     bitClockOut,
   output logic                     bitClockOe,
   input  wire logic                rxFrameClockIn,
   output logic                     rxFrameClockOut,
   output logic                     rxFrameClockOe,
   input  wire logic                txFrameClockIn,
   output logic                     txFrameClockOut,
   output logic                     txFrameClockOe,
   output logic                     portBitClock,
   output logic                     rxPathFrame,
   output logic                     txPathFrame,
   input  wire logic [2*DATA_W-1:0] port2RxData,
   input  wire logic [2*DATA_W-1:0] port1Ch23Data,
   output logic      [2*DATA_W-1:0] dspInData
);
   if (DATA_W < 1 || DATA_W > 32)
   begin : gDataWCheck
      $error("DATA_W out of range");
   end

   // Bit clock ratio from divider code
   function automatic logic [6:0] bitDivRatio(input logic [3:0] code);
      logic [6:0] r;
      r = acg_pkg::DIV_96;
      case (code)
         4'h0: r = acg_pkg::DIV_1;
         4'h1: r = acg_pkg::DIV_2;
         4'h2: r = acg_pkg::DIV_3;
         4'h3: r = acg_pkg::DIV_4;
         4'h4: r = acg_pkg::DIV_6;
         4'h5: r = acg_pkg::DIV_8;
         4'h6: r = acg_pkg::DIV_12;
         4'h7: r = acg_pkg::DIV_16;
         4'h8: r = acg_pkg::DIV_24;
         4'h9: r = acg_pkg::DIV_32;
         4'ha: r = acg_pkg::DIV_48;
         4'hb: r = acg_pkg::DIV_64;
         default: r = acg_pkg::DIV_96;
      endcase
      return r;
   endfunction : bitDivRatio

   // Frame rate with values below the minimum lifted to it
   function automatic logic [10:0] frameRatio(input logic [15:0] rate);
      logic [10:0] v;
      v = rate[acg_pkg::RATE_W-1:0];
      if (v < acg_pkg::RATE_MIN)
      begin
         v = acg_pkg::RATE_MIN;
      end
      return v;
   endfunction : frameRatio

   // Frame counter step on a bit clock edge
   function automatic logic [10:0] frameStep(input logic [10:0] cnt, input logic [10:0] ratio);
      logic [10:0] n;
      n = cnt + 11'h001;
      if (n >= ratio)
      begin
         n = 11'h000;
      end
      return n;
   endfunction : frameStep

   // Register state
   logic [15:0]          pathCtrl;
   logic [15:0]          bitClockCtrl;
   logic [15:0]          txFrameRate;
   logic [15:0]          txFrameCtrl;
   logic [15:0]          rxFrameRate;
   logic [15:0]          rxFrameCtrl;
   logic [15:0]          next_pathCtrl;
   logic [15:0]          next_bitClockCtrl;
   logic [15:0]          next_txFrameRate;
   logic [15:0]          next_txFrameCtrl;
   logic [15:0]          next_rxFrameRate;
   logic [15:0]          next_rxFrameCtrl;
   logic [31:0]          next_prdata;
   logic                 next_pready;
   logic                 next_pslverr;
   acg_pkg::acg_bus_e    busState;
   acg_pkg::acg_bus_e    next_busState;
   logic [11:0]          regIdx;
   logic                 idxHit;
   logic [15:0]          readVal;

   assign regIdx = paddr[acg_pkg::ADDR_SHIFT +: 12];

   always_comb
   begin
      idxHit = 1'b1;
      readVal = 16'h0000;
      if (regIdx == acg_pkg::IDX_PATH_CTRL)
      begin
         readVal = pathCtrl;
      end
      else if (regIdx == acg_pkg::IDX_BIT_CLOCK_CTRL)
      begin
         readVal = bitClockCtrl;
      end
      else if (regIdx == acg_pkg::IDX_TX_FRAME_RATE)
      begin
         readVal = txFrameRate;
      end
      else if (regIdx == acg_pkg::IDX_TX_FRAME_CTRL)
      begin
         readVal = txFrameCtrl;
      end
      else if (regIdx == acg_pkg::IDX_RX_FRAME_RATE)
      begin
         readVal = rxFrameRate;
      end
      else if (regIdx == acg_pkg::IDX_RX_FRAME_CTRL)
      begin
         readVal = rxFrameCtrl;
      end
      else
      begin
         idxHit = 1'b0;
      end
      if (paddr[1:0] != 2'h0 || paddr[31:14] != 18'h00000)
      begin
         idxHit = 1'b0;
         readVal = 16'h0000;
      end
   end

   // APB slave: one wait state, write lands at the edge that ends the ready cycle
   always_comb
   begin
      next_busState = busState;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      next_prdata = prdata;
      next_pathCtrl = pathCtrl;
      next_bitClockCtrl = bitClockCtrl;
      next_txFrameRate = txFrameRate;
      next_txFrameCtrl = txFrameCtrl;
      next_rxFrameRate = rxFrameRate;
      next_rxFrameCtrl = rxFrameCtrl;
      case (busState)
         acg_pkg::ACG_IDLE:
         begin
            if (psel && penable)
            begin
               next_busState = acg_pkg::ACG_ACCESS;
               next_pready = 1'b1;
               next_pslverr = !idxHit;
               next_prdata = (pwrite || !idxHit) ? 32'h00000000 : {16'h0000, readVal};
            end
         end
         acg_pkg::ACG_ACCESS:
         begin
            next_busState = acg_pkg::ACG_IDLE;
            if (pwrite && idxHit)
            begin
               if (regIdx == acg_pkg::IDX_PATH_CTRL)
               begin
                  next_pathCtrl = pwdata[15:0] & acg_pkg::MSK_PATH_CTRL;
               end
               else if (regIdx == acg_pkg::IDX_BIT_CLOCK_CTRL)
               begin
                  next_bitClockCtrl = pwdata[15:0] & acg_pkg::MSK_BIT_CLOCK_CTRL;
               end
               else if (regIdx == acg_pkg::IDX_TX_FRAME_RATE)
               begin
                  next_txFrameRate = pwdata[15:0] & acg_pkg::MSK_FRAME_RATE;
               end
               else if (regIdx == acg_pkg::IDX_TX_FRAME_CTRL)
               begin
                  next_txFrameCtrl = pwdata[15:0] & acg_pkg::MSK_TX_FRAME_CTRL;
               end
               else if (regIdx == acg_pkg::IDX_RX_FRAME_RATE)
               begin
                  next_rxFrameRate = pwdata[15:0] & acg_pkg::MSK_FRAME_RATE;
               end
               else
               begin
                  next_rxFrameCtrl = pwdata[15:0] & acg_pkg::MSK_RX_FRAME_CTRL;
               end
            end
         end
         default:
         begin
            next_busState = acg_pkg::ACG_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         busState <= acg_pkg::ACG_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         pathCtrl <= acg_pkg::RST_PATH_CTRL;
         bitClockCtrl <= acg_pkg::RST_BIT_CLOCK_CTRL;
         txFrameRate <= acg_pkg::RST_FRAME_RATE;
         txFrameCtrl <= acg_pkg::RST_TX_FRAME_CTRL;
         rxFrameRate <= acg_pkg::RST_FRAME_RATE;
         rxFrameCtrl <= acg_pkg::RST_RX_FRAME_CTRL;
      end
      else
      begin
         busState <= next_busState;
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
         pathCtrl <= next_pathCtrl;
         bitClockCtrl <= next_bitClockCtrl;
         txFrameRate <= next_txFrameRate;
         txFrameCtrl <= next_txFrameCtrl;
         rxFrameRate <= next_rxFrameRate;
         rxFrameCtrl <= next_rxFrameCtrl;
      end
   end

   // Decoded controls
   logic        rxAnyEn;
   logic        txAnyEn;
   logic        bitMaster;
   logic        bitForce;
   logic        bitInvert;
   logic        txSeparate;
   logic [6:0]  bitRatio;
   logic [10:0] rxRatio;
   logic [10:0] txRatio;

   assign rxAnyEn = |pathCtrl[acg_pkg::F_RX_EN_HI:acg_pkg::F_RX_EN_LO];
   assign txAnyEn = |pathCtrl[acg_pkg::F_TX_EN_HI:acg_pkg::F_TX_EN_LO];
   assign bitMaster = bitClockCtrl[acg_pkg::F_BCLK_MSTR];
   assign bitForce = bitClockCtrl[acg_pkg::F_BCLK_FRC];
   assign bitInvert = bitClockCtrl[acg_pkg::F_BCLK_INV];
   assign bitRatio = bitDivRatio(bitClockCtrl[acg_pkg::F_BCLK_DIV_HI:acg_pkg::F_BCLK_DIV_LO]);
   assign rxRatio = frameRatio(rxFrameRate);
   assign txRatio = frameRatio(txFrameRate);
   // Mode bit clear selects own transmit frame clock, only with the pin set for it
   assign txSeparate = !txFrameCtrl[acg_pkg::F_FR_MODE]
      && pathCtrl[acg_pkg::F_PIN_TX_FN];

   // Clock state
   logic            audioPrev;
   logic [6:0]      bitCnt;
   logic            bitGen;
   logic            bitInt;
   logic            bitPrev;
   logic [10:0]     rxCnt;
   logic [10:0]     txCnt;
   logic            next_audioPrev;
   logic [6:0]      next_bitCnt;
   logic            next_bitGen;
   logic            next_bitInt;
   logic            next_bitPrev;
   logic [10:0]     next_rxCnt;
   logic [10:0]     next_txCnt;
   logic            bitRise;
   acg_pkg::acg_pin_s bitPin;
   acg_pkg::acg_pin_s rxPin;
   acg_pkg::acg_pin_s txPin;
   logic            rxGen;
   logic            txGen;
   logic            rxInt;
   logic            txInt;
   logic            next_rxPath;
   logic            next_txPath;
   logic [2*DATA_W-1:0] next_dspIn;

   always_comb
   begin
      next_audioPrev = audioSystemClock;
      next_bitCnt = bitCnt;
      // Divide on audio system clock rising edges
      if (audioSystemClock && !audioPrev)
      begin
         next_bitCnt = (bitCnt + 7'h01 >= bitRatio) ? 7'h00 : bitCnt + 7'h01;
      end
      // High for the first half of each divided period, rounded up for odd ratios; undivided follows the clock
      if (bitRatio == acg_pkg::DIV_1)
      begin
         next_bitGen = audioSystemClock;
      end
      else
      begin
         next_bitGen = ({next_bitCnt, 1'b0} < {1'b0, bitRatio});
      end
      // Generated clock in master or forced, else the pin
      if (bitMaster || bitForce)
      begin
         next_bitInt = bitGen;
      end
      else
      begin
         next_bitInt = bitClockIn ^ bitInvert;
      end
      next_bitPrev = bitInt;
   end

   assign bitRise = bitInt && !bitPrev;

   // Frame dividers count bit clock rising edges; no bit clock means no frames
   always_comb
   begin
      next_rxCnt = rxCnt;
      next_txCnt = txCnt;
      if (bitRise)
      begin
         next_rxCnt = frameStep(rxCnt, rxRatio);
         next_txCnt = frameStep(txCnt, txRatio);
      end
   end

   assign rxGen = ({rxCnt, 1'b0} < {1'b0, rxRatio});
   assign txGen = ({txCnt, 1'b0} < {1'b0, txRatio});

   // Pin drivers and internal frame sources
   always_comb
   begin
      bitPin.out = bitGen ^ bitInvert;
      bitPin.oe = bitForce || (bitMaster && (rxAnyEn || txAnyEn));
      rxPin.out = rxGen ^ rxFrameCtrl[acg_pkg::F_FR_INV];
      rxPin.oe = rxFrameCtrl[acg_pkg::F_FR_FRC];
      if (rxFrameCtrl[acg_pkg::F_FR_MSTR])
      begin
         rxPin.oe = rxPin.oe || (txSeparate ? rxAnyEn : (rxAnyEn || txAnyEn));
      end
      txPin.out = txGen ^ txFrameCtrl[acg_pkg::F_FR_INV];
      txPin.oe = 1'b0;
      if (txSeparate)
      begin
         txPin.oe = txFrameCtrl[acg_pkg::F_FR_FRC]
            || (txFrameCtrl[acg_pkg::F_FR_MSTR] && txAnyEn);
      end
      if (rxFrameCtrl[acg_pkg::F_FR_MSTR] || rxFrameCtrl[acg_pkg::F_FR_FRC])
      begin
         rxInt = rxGen;
      end
      else
      begin
         rxInt = rxFrameClockIn ^ rxFrameCtrl[acg_pkg::F_FR_INV];
      end
      if (txFrameCtrl[acg_pkg::F_FR_MSTR] || txFrameCtrl[acg_pkg::F_FR_FRC])
      begin
         txInt = txGen;
      end
      else
      begin
         txInt = txFrameClockIn ^ txFrameCtrl[acg_pkg::F_FR_INV];
      end
      next_rxPath = rxInt;
      next_txPath = txSeparate ? txInt : rxInt;
      next_dspIn = pathCtrl[acg_pkg::F_DSP_SRC] ? port1Ch23Data : port2RxData;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         audioPrev <= 1'b0;
         bitCnt <= 7'h00;
         bitGen <= 1'b0;
         bitInt <= 1'b0;
         bitPrev <= 1'b0;
         rxCnt <= 11'h000;
         txCnt <= 11'h000;
         bitClockOut <= 1'b0;
         bitClockOe <= 1'b0;
         rxFrameClockOut <= 1'b0;
         rxFrameClockOe <= 1'b0;
         txFrameClockOut <= 1'b0;
         txFrameClockOe <= 1'b0;
         portBitClock <= 1'b0;
         rxPathFrame <= 1'b0;
         txPathFrame <= 1'b0;
         dspInData <= '0;
      end
      else
      begin
         audioPrev <= next_audioPrev;
         bitCnt <= next_bitCnt;
         bitGen <= next_bitGen;
         bitInt <= next_bitInt;
         bitPrev <= next_bitPrev;
         rxCnt <= next_rxCnt;
         txCnt <= next_txCnt;
         bitClockOut <= bitPin.out;
         bitClockOe <= bitPin.oe;
         rxFrameClockOut <= rxPin.out;
         rxFrameClockOe <= rxPin.oe;
         txFrameClockOut <= txPin.out;
         txFrameClockOe <= txPin.oe;
         portBitClock <= bitInt;
         rxPathFrame <= next_rxPath;
         txPathFrame <= next_txPath;
         dspInData <= next_dspIn;
      end
   end
endmodule : acg_clock_gen

/* tb/acg_clock_gen_asserts.sv */
// Port relation checker for the port-two clock generator
`timescale 1ns/1ps
module acg_clock_gen_asserts #(
   parameter int unsigned DATA_W = 24
) (
   input wire logic                ref_clk,
   input wire logic                nrst,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire logic                bitClockOe,
   input wire logic                rxFrameClockOe,
   input wire logic                txFrameClockOe,
   input wire logic [2*DATA_W-1:0] port2RxData,
   input wire logic [2*DATA_W-1:0] port1Ch23Data,
   input wire logic [2*DATA_W-1:0] dspInData
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   apb_answer_a: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered after one wait state");
   ready_cause_a: assert property (pready |-> $past(psel && penable))
      else $error("ready without an access");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error response malformed");
   upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0)
      else $error("upper read bits not zero");
   reset_quiet_a: assert property (disable iff (1'b0) !nrst |=>
      !bitClockOe && !rxFrameClockOe && !txFrameClockOe && !pready)
      else $error("drivers on during reset");
   oe_cause_a: assert property ($changed({bitClockOe, rxFrameClockOe, txFrameClockOe})
      |-> $past(pready) || $past(pready, 2) || $past(pready, 3))
      else $error("pin driver changed without a write");
   dsp_source_a: assert property ($past(nrst) && $past(nrst, 2) |->
      dspInData == $past(port2RxData) || dspInData == $past(port1Ch23Data))
      else $error("dsp input not from a source");
endmodule : acg_clock_gen_asserts

/* tb/acg_far_end.sv */
// Far-side audio processor: supplies bit and frame clocks while running
`timescale 1ns/1ps
module acg_far_end #(
   parameter int HALF  = 5,
   parameter int FRAME = 8
) (
   input  wire logic ref_clk,
   input  wire logic run,
   output logic      bitClk,
   output logic      frameClk
);
   int cnt = 0;
   int bits = 0;
   initial
   begin
      bitClk = 1'b0;
      frameClk = 1'b0;
   end
   // Bit clock stands still while stopped; frame high first half of bits
   always @(posedge ref_clk)
   begin
      if (run && cnt == HALF - 1)
      begin
         cnt <= 0;
         bitClk <= ~bitClk;
         if (bitClk)
         begin
            bits <= (bits == FRAME - 1) ? 0 : bits + 1;
            frameClk <= (bits == FRAME - 1) || (bits + 1 < FRAME / 2);
         end
      end
      else if (run)
         cnt <= cnt + 1;
   end
endmodule : acg_far_end

/* tb/acg_clock_gen_tb.sv */
// Self-checking bench for the port-two clock generator
`timescale 1ns/1ps
module acg_clock_gen_tb;
   localparam int unsigned DATA_W = 24;
   localparam logic [11:0] pc = acg_pkg::IDX_PATH_CTRL;
   localparam logic [11:0] bc = acg_pkg::IDX_BIT_CLOCK_CTRL;
   localparam logic [11:0] tc = acg_pkg::IDX_TX_FRAME_CTRL;
   localparam logic [11:0] rc = acg_pkg::IDX_RX_FRAME_CTRL;
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q, rnd;
   logic        pready, pslverr, e, farRun = 1'b0, farBit, farFrame;
   logic        audioSystemClock = 1'b0;
   logic [1:0]  acnt = 2'h0;
   logic        bitClockIn, bitClockOut, bitClockOe, portBitClock;
   logic        rxFrameClockIn, rxFrameClockOut, rxFrameClockOe, rxPathFrame;
   logic        txFrameClockIn, txFrameClockOut, txFrameClockOe, txPathFrame;
   logic [47:0] port2RxData = 48'h0, port1Ch23Data = 48'h0, dspInData, dsel;
   int          badCount = 0, numChecks = 0, i, hi, per;
   logic [15:0] rstv [6] = '{16'h0, 16'h0, 16'h80, 16'h8, 16'h80, 16'h0};
   logic [15:0] mskv [6] = '{16'h11f, 16'h70f, 16'h7ff, 16'hf, 16'h7ff, 16'h7};
   int          dv [16] = '{1, 2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 96, 96, 96};
   logic [11:0] sIdx [12] = '{bc, pc, rc, bc, bc, tc, pc, tc, rc, tc, rc, pc};
   logic [15:0] sDat [12] = '{16'h101, 16'h1, 16'h1, 16'h1, 16'h201, 16'h1,
                              16'h104, 16'h9, 16'h2, 16'h2, 16'h0, 16'h0};
   logic [2:0]  sOe [12] = '{3'h0, 3'h4, 3'h6, 3'h2, 3'h6, 3'h6, 3'h5, 3'h6, 3'h6, 3'h7,
                             3'h5, 3'h4};
   assign bitClockIn = bitClockOe ? bitClockOut : farBit;
   assign rxFrameClockIn = rxFrameClockOe ? rxFrameClockOut : farFrame;
   assign txFrameClockIn = txFrameClockOe ? txFrameClockOut : farFrame;
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      acnt <= acnt + 2'h1;
      audioSystemClock <= acnt[1];
   end
   acg_far_end u_far (.ref_clk(ref_clk), .run(farRun), .bitClk(farBit), .frameClk(farFrame));
   acg_clock_gen #(.DATA_W(DATA_W)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .audioSystemClock(audioSystemClock),
      .bitClockIn(bitClockIn), .bitClockOut(bitClockOut), .bitClockOe(bitClockOe),
      .rxFrameClockIn(rxFrameClockIn), .rxFrameClockOut(rxFrameClockOut),
      .rxFrameClockOe(rxFrameClockOe), .txFrameClockIn(txFrameClockIn),
      .txFrameClockOut(txFrameClockOut), .txFrameClockOe(txFrameClockOe),
      .portBitClock(portBitClock), .rxPathFrame(rxPathFrame), .txPathFrame(txPathFrame),
      .port2RxData(port2RxData), .port1Ch23Data(port1Ch23Data), .dspInData(dspInData));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp)
      begin
         badCount++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge ref_clk);
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] idx, input logic [15:0] d);
      apb(1'b1, {18'h0, idx, 2'b00}, {16'h0, d});
   endtask : wr
   task automatic rdc(input logic [11:0] idx, input logic [15:0] exp);
      apb(1'b0, {18'h0, idx, 2'b00}, 32'h0);
      chk(q, {16'h0, exp});
   endtask : rdc
   function automatic logic sig(input int w);
      case (w)
         0: return portBitClock;
         1: return rxFrameClockOut;
         2: return txFrameClockOut;
         3: return rxPathFrame;
         default: return txPathFrame;
      endcase
   endfunction : sig
   // Second full period of the chosen clock: high count and length
   task automatic meas(input int w);
      logic p;
      logic s;
      int   n;
      int   r;
      p = 1'b1;
      r = 0;
      hi = 0;
      per = 0;
      for (n = 0; n < 4000 && r < 3; n++)
      begin
         @(posedge ref_clk);
         #1;
         s = sig(w);
         if (s === 1'b1 && p === 1'b0)
            r++;
         if (r == 2)
            per++;
         if (r == 2 && s === 1'b1)
            hi++;
         p = s;
      end
   endtask : meas
   task automatic final_report();
      if (badCount == 0 && numChecks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   initial
   begin
      #400_000;
      badCount++;
      final_report();
   end
   initial
   begin
      rnd = $urandom(32'h74e767b9);
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      for (i = 0; i < 6; i++)
         rdc(12'h320 + 12'(i), rstv[i]);
      apb(1'b0, 32'h0000_0c98, 32'h0);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, 32'h0000_0c86, 32'h5);
      chk({31'h0, e}, 32'h1);
      rdc(bc, 16'h0);
      for (i = 0; i < 6; i++)
      begin
         rnd = $urandom;
         wr(12'h320 + 12'(i), rnd[15:0]);
         rdc(12'h320 + 12'(i), rnd[15:0] & mskv[i]);
         wr(12'h320 + 12'(i), rstv[i]);
      end
      for (i = 0; i < 4; i++)
      begin
         rnd = $urandom;
         port2RxData <= 48'({$urandom, $urandom});
         port1Ch23Data <= 48'({$urandom, $urandom});
         wr(pc, {11'h0, rnd[0], 4'h0});
         @(posedge ref_clk);
         #1;
         dsel = rnd[0] ? port1Ch23Data : port2RxData;
         chk(dspInData[31:0], dsel[31:0]);
         chk({16'h0, dspInData[47:32]}, {16'h0, dsel[47:32]});
      end
      for (i = 0; i < 12; i++)
      begin
         wr(sIdx[i], sDat[i]);
         repeat (4) @(posedge ref_clk);
         q = {29'h0, bitClockOe, rxFrameClockOe, txFrameClockOe};
         chk(q, {29'h0, sOe[i]});
      end
      wr(pc, 16'h0001);
      for (i = 0; i < 16; i++)
      begin
         wr(bc, 16'h0100 | 16'(i));
         meas(0);
         chk(32'(per), 32'(4 * dv[i]));
      end
      for (i = 0; i < 2; i++)
      begin
         wr(bc, 16'h010b | 16'(i << 10));
         meas(0);
         repeat (60) @(posedge ref_clk);
         #1;
         chk({31'h0, bitClockOut}, {31'h0, portBitClock ^ i[0]});
      end
      wr(bc, 16'h0101);
      wr(rc, 16'h0001);
      wr(acg_pkg::IDX_RX_FRAME_RATE, 16'd9);
      for (i = 0; i < 2; i++)
      begin
         wr(rc, 16'h0001 | 16'(i << 2));
         meas(1);
         chk(32'(per), 32'd72);
         chk(32'(hi), 32'((5 - i) * 8));
      end
      wr(pc, 16'h0104);
      wr(tc, 16'h0001);
      wr(acg_pkg::IDX_TX_FRAME_RATE, 16'd8);
      meas(2);
      chk(32'(per), 32'd64);
      meas(4);
      chk(32'(per), 32'd64);
      wr(pc, 16'h0000);
      wr(bc, 16'h0000);
      wr(rc, 16'h0002);
      wr(acg_pkg::IDX_RX_FRAME_RATE, 16'd8);
      meas(1);
      chk(32'(per), 32'd0);
      farRun <= 1'b1;
      meas(1);
      chk(32'(per), 32'd80);
      wr(rc, 16'h0000);
      meas(3);
      chk(32'(per), 32'd80);
      meas(4);
      chk(32'(per), 32'd80);
      final_report();
   end
endmodule : acg_clock_gen_tb
bind acg_clock_gen acg_clock_gen_asserts #(.DATA_W(DATA_W)) u_chk (.ref_clk(ref_clk),
   .nrst(nrst), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .bitClockOe(bitClockOe), .rxFrameClockOe(rxFrameClockOe),
   .txFrameClockOe(txFrameClockOe), .port2RxData(port2RxData),
   .port1Ch23Data(port1Ch23Data), .dspInData(dspInData));
